/* File: hw/pin_cell.sv */
// One port pin: function choice, drive, pull-up and mode-dependent hold
`timescale 1ns/1ps
module pin_cell (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic dir_i,
  input wire logic pullup_i,
  input wire logic data_i,
  input wire logic alt_sel_i,
  input wire logic alt_is_out_i,
  input wire logic alt_out_i,
  // Operating mode
  input wire logic normal_i,
  input wire logic standby_i,
  // Pad drive
  output logic pad_o,
  output logic pad_oe_n_o,
  output logic pullup_on_o
);
  // Drive wanted in functional modes
  logic want_drive;
  logic want_level;
  // Pull-up from the programmed bits
  logic pull_on;

  // Alternate function overrides the direction bit
  always_comb begin
    if (alt_sel_i) begin
      want_drive = alt_is_out_i;
      want_level = alt_out_i;
    end else begin
      want_drive = dir_i;
      want_level = data_i;
    end
  end

  // Pull-up only on a port input with its enable set
  assign pull_on = !dir_i && pullup_i;

  // Pad state per mode; hold modes simply keep the last value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= 1'b0;
      pad_oe_n_o <= 1'b1;
      pullup_on_o <= 1'b0;
    end else if (standby_i) begin
      pad_o <= pull_on;
      pad_oe_n_o <= !pull_on;
      pullup_on_o <= pull_on;
    end else if (normal_i) begin
      pad_o <= want_level;
      pad_oe_n_o <= !want_drive;
      pullup_on_o <= pull_on;
    end
  end
endmodule : pin_cell

/* File: hw/port1_low_pin_mux.sv */
// Port one pin mux top with Wishbone register slave
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module port1_low_pin_mux
  import port_one_pkg::*;
#(
  parameter int WIDTH = port_one_pkg::PIN_COUNT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Timer side
  input wire logic timer_wave_i,
  input wire logic timer_low_ovf_i,
  input wire logic timer_high_ovf_i,
  output logic timer_capture_o,
  // Pads
  input wire logic [WIDTH-1:0] general_port_one_i,
  output logic [WIDTH-1:0] general_port_one_o,
  output logic [WIDTH-1:0] general_port_one_oe_n_o,
  output logic [WIDTH-1:0] pullup_on_o
);
  import port_one_pkg::*;

  // Software registers
  logic [WIDTH-1:0] port_data;
  logic [WIDTH-1:0] port_one_direction_reg;
  logic [7:0] port_one_mode_reg;
  logic [WIDTH-1:0] port_one_pullup_reg;
  op_mode_t op_mode;
  // Pin synchroniser, first stage read only by the second
  logic [WIDTH-1:0] pin_meta;
  logic [WIDTH-1:0] pin_sync;
  // Bus strobes
  logic access;
  logic wr;
  // Alternate function selects and outputs per pin
  logic [WIDTH-1:0] alt_sel;
  logic [WIDTH-1:0] alt_is_out;
  logic [WIDTH-1:0] alt_out;
  logic normal;
  logic standby;

  // Decode a three-bit mode code to a one-hot mode
  function automatic op_mode_t decode_mode(input logic [2:0] code, input op_mode_t cur);
    case (code)
      OPCODE_ACTIVE: decode_mode = OP_ACTIVE;
      OPCODE_SUBACTIVE: decode_mode = OP_SUBACTIVE;
      OPCODE_SLEEP: decode_mode = OP_SLEEP;
      OPCODE_SUBSLEEP: decode_mode = OP_SUBSLEEP;
      OPCODE_WATCH: decode_mode = OP_WATCH;
      OPCODE_STANDBY: decode_mode = OP_STANDBY;
      default: decode_mode = cur; // Unused codes leave the mode alone
    endcase
  endfunction : decode_mode

  // Encode the one-hot mode for readback
  function automatic logic [2:0] encode_mode(input op_mode_t m);
    unique case (m)
      OP_ACTIVE: encode_mode = OPCODE_ACTIVE;
      OP_SUBACTIVE: encode_mode = OPCODE_SUBACTIVE;
      OP_SLEEP: encode_mode = OPCODE_SLEEP;
      OP_SUBSLEEP: encode_mode = OPCODE_SUBSLEEP;
      OP_WATCH: encode_mode = OPCODE_WATCH;
      OP_STANDBY: encode_mode = OPCODE_STANDBY;
      default: encode_mode = OPCODE_ACTIVE;
    endcase
  endfunction : encode_mode

  // A new request is one not already acknowledged
  assign access = cyc_i && stb_i && !ack_o;
  assign wr = access && we_i && sel_i[0];

  // Single-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // Register writes through byte lane zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_data <= DATA_RESET;
      port_one_direction_reg <= DIRECTION_RESET;
      port_one_mode_reg <= MODE_RESET;
      port_one_pullup_reg <= PULLUP_RESET;
    end else if (wr) begin
      case (adr_i)
        ADR_DATA: port_data <= dat_i[WIDTH-1:0];
        ADR_DIRECTION: port_one_direction_reg <= dat_i[WIDTH-1:0];
        ADR_MODE: port_one_mode_reg <= {4'h0, dat_i[3:0]};
        ADR_PULLUP: port_one_pullup_reg <= dat_i[WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // Operating mode, set by software; reset returns to active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_mode <= OP_ACTIVE;
    end else if (wr && adr_i == ADR_OPMODE) begin
      op_mode <= decode_mode(dat_i[2:0], op_mode);
    end
  end

  assign normal = (op_mode == OP_ACTIVE) || (op_mode == OP_SUBACTIVE);
  assign standby = (op_mode == OP_STANDBY);

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (access && !we_i) begin
      case (adr_i)
        ADR_DATA: dat_o <= {24'h000000, port_data};
        ADR_DIRECTION: dat_o <= {24'h000000, port_one_direction_reg};
        ADR_MODE: dat_o <= {24'h000000, port_one_mode_reg};
        ADR_PULLUP: dat_o <= {24'h000000, port_one_pullup_reg};
        ADR_PINS: dat_o <= {24'h000000, pin_sync};
        ADR_OPMODE: dat_o <= {29'h00000000, encode_mode(op_mode)};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Two-flop synchroniser on the pad inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= general_port_one_i;
      pin_sync <= pin_meta;
    end
  end

  // Capture input routed from pin 3 only while selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_capture_o <= 1'b0;
    end else begin
      timer_capture_o <= port_one_mode_reg[CAPTURE_BIT] & pin_sync[3];
    end
  end

  // Alternate function table for the low four pins
  always_comb begin
    alt_sel = '0;
    alt_is_out = '0;
    alt_out = '0;
    alt_sel[3] = port_one_mode_reg[CAPTURE_BIT];
    alt_is_out[3] = 1'b0;
    alt_sel[2] = port_one_mode_reg[HIGH_OVF_BIT];
    alt_is_out[2] = 1'b1;
    alt_out[2] = timer_high_ovf_i;
    alt_sel[1] = port_one_mode_reg[LOW_OVF_BIT];
    alt_is_out[1] = 1'b1;
    alt_out[1] = timer_low_ovf_i;
    alt_sel[0] = port_one_mode_reg[WAVE_OUT_BIT];
    alt_is_out[0] = 1'b1;
    alt_out[0] = timer_wave_i;
  end

  // One cell per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_pin
      pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dir_i(port_one_direction_reg[g]),
        .pullup_i(port_one_pullup_reg[g]),
        .data_i(port_data[g]),
        .alt_sel_i(alt_sel[g]),
        .alt_is_out_i(alt_is_out[g]),
        .alt_out_i(alt_out[g]),
        .normal_i(normal),
        .standby_i(standby),
        .pad_o(general_port_one_o[g]),
        .pad_oe_n_o(general_port_one_oe_n_o[g]),
        .pullup_on_o(pullup_on_o[g])
      );
    end
  endgenerate
endmodule : port1_low_pin_mux

/* File: include/port_one_pkg.sv */
// Package for the port one pin function and pin state logic
package port_one_pkg;
  // Number of pins on the port
  localparam int PIN_COUNT = 8;
  // Register byte offsets, 5 bits wide to match the address compare
  localparam logic [4:0] ADR_DATA = 5'h00;
  localparam logic [4:0] ADR_DIRECTION = 5'h04;
  localparam logic [4:0] ADR_MODE = 5'h08;
  localparam logic [4:0] ADR_PULLUP = 5'h0C;
  localparam logic [4:0] ADR_PINS = 5'h10;
  localparam logic [4:0] ADR_OPMODE = 5'h14;
  // Mode register bit positions
  localparam int WAVE_OUT_BIT = 0;
  localparam int LOW_OVF_BIT = 1;
  localparam int HIGH_OVF_BIT = 2;
  localparam int CAPTURE_BIT = 3;
  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    OP_ACTIVE = 6'h01,
    OP_SUBACTIVE = 6'h02,
    OP_SLEEP = 6'h04,
    OP_SUBSLEEP = 6'h08,
    OP_WATCH = 6'h10,
    OP_STANDBY = 6'h20
  } op_mode_t;
  localparam logic [2:0] OPCODE_ACTIVE = 3'h0;
  localparam logic [2:0] OPCODE_SUBACTIVE = 3'h1;
  localparam logic [2:0] OPCODE_SLEEP = 3'h2;
  localparam logic [2:0] OPCODE_SUBSLEEP = 3'h3;
  localparam logic [2:0] OPCODE_WATCH = 3'h4;
  localparam logic [2:0] OPCODE_STANDBY = 3'h5;
endpackage : port_one_pkg

/* File: tb/board_model.sv */
// Board and timer model on the far side of port one
`timescale 1ns/1ps
module board_model (
  // Board levels and the pad drive of the mux
  input wire logic [7:0] ext_i, pad_i, oe_n_i, pu_i,
  // Timer levels as {high overflow, low overflow, wave}, set by the bench
  input wire logic [2:0] tmr_i,
  // Pin levels and timer outputs
  output logic [7:0] level_o,
  output logic wave_o, low_o, high_o
);
  // Timer levels differ from the port data so a wrong route shows
  assign {high_o, low_o, wave_o} = tmr_i;
  // A released pin follows its pull-up, else the board
  assign level_o = (~oe_n_i & pad_i) | (oe_n_i & (pu_i | ext_i));
endmodule : board_model

/* File: tb/port_mux_props.sv */
// Checker for bus handshake and pin states of the port mux
`timescale 1ns/1ps
module port_mux_props
  import port_one_pkg::*;
#(parameter int WIDTH = 8) (
  // Clock, reset and bus
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  // Timer and pins
  input wire logic timer_capture_o,
  input wire logic [WIDTH-1:0] general_port_one_o, general_port_one_oe_n_o, pullup_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Register shadows, taken at the edge that accepts the request, before ack
  logic [WIDTH-1:0] dir, mode, pu, drv;
  logic [2:0] op;
  logic wr, norm;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign norm = op <= OPCODE_SUBACTIVE;
  // Pin 3 drives only as port output; pins 2..0 also for a timer output
  assign drv = (dir & ~(mode & 8'h08)) | (mode & 8'h07);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir <= 8'h00;
      mode <= 8'h00;
      pu <= 8'h00;
      op <= 3'h0;
    end else if (wr) begin
      if (adr_i == ADR_DIRECTION) dir <= dat_i[WIDTH-1:0];
      if (adr_i == ADR_MODE) mode <= {4'h0, dat_i[3:0]};
      if (adr_i == ADR_PULLUP) pu <= dat_i[WIDTH-1:0];
      // Codes 6 and 7 are ignored
      if (adr_i == ADR_OPMODE && dat_i[2:0] < 3'h6) op <= dat_i[2:0];
    end
  end
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_next_cycle: assert property (s_req |=> ack_o) else $error("ack late");
  a_ack_single_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_reset_float: assert property (disable iff (1'b0) rst_i |=>
    &general_port_one_oe_n_o && pullup_on_o == '0) else $error("pins active in reset");
  a_pullup_gate: assert property ($past(norm) |-> pullup_on_o == $past(pu & ~dir))
    else $error("pull-up wrong");
  a_pin_enables: assert property ($past(norm) |->
    general_port_one_oe_n_o == ~$past(drv)) else $error("pin enable wrong");
  a_capture_gated: assert property ($past(norm && !mode[CAPTURE_BIT]) |-> !timer_capture_o)
    else $error("capture not gated");
  a_standby_drive: assert property ($past(op == OPCODE_STANDBY) |->
    general_port_one_oe_n_o == ~$past(pu & ~dir) && &(general_port_one_o | general_port_one_oe_n_o))
    else $error("standby pins wrong");
  a_sleep_hold: assert property ($past(op inside {3'h2, 3'h3, 3'h4}) |->
    $stable(general_port_one_o) && $stable(general_port_one_oe_n_o) && $stable(pullup_on_o))
    else $error("pins moved while held");
endmodule : port_mux_props
bind port1_low_pin_mux port_mux_props #(.WIDTH(WIDTH)) props (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .ack_o, .adr_i, .sel_i, .dat_i, .timer_capture_o, .general_port_one_o,
  .general_port_one_oe_n_o, .pullup_on_o);

/* File: tb/testbench.sv */
// Self-checking bench for the port one pin mux
`timescale 1ns/1ps
module testbench;
  import port_one_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o, wave, lovf, hovf, cap;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  // Byte lanes on the bus, copied from lanes at each request
  logic [3:0] sel = 4'hF, lanes = 4'hF;
  // Timer levels differ from the port data so a wrong route shows
  logic [2:0] tmr = 3'h5;
  // Board holds pin 3 high, the rest low
  logic [7:0] ext = 8'h08, lvl, pad_o, oe_n, pu_on;
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  port1_low_pin_mux uut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o, .ack_o, .timer_wave_i(wave), .timer_low_ovf_i(lovf),
    .timer_high_ovf_i(hovf), .timer_capture_o(cap), .general_port_one_i(lvl),
    .general_port_one_o(pad_o), .general_port_one_oe_n_o(oe_n), .pullup_on_o(pu_on));
  board_model partner (.ext_i(ext), .pad_i(pad_o), .oe_n_i(oe_n), .pu_i(pu_on), .tmr_i(tmr),
    .level_o(lvl), .wave_o(wave), .low_o(lovf), .high_o(hovf));
  // Classic cycle: hold the request until ack is seen at an edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    // Ack is sampled at rising edges only; the request stands until then
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Pads follow a register write one edge later
  task automatic settle;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    chk(oe_n, 8'hFF);
    chk(pu_on, 8'h00);
    wb(1'b1, ADR_DIRECTION, 32'hFF);
    wb(1'b1, ADR_DATA, 32'h5A);
    settle;
    chk(oe_n, 8'h00);
    chk(pad_o, 8'h5A);
    wb(1'b1, ADR_MODE, 32'h0F);
    settle;
    chk(oe_n, 8'h08);
    chk(pad_o[2:0], 3'h5);
    chk(cap, 1'b1);
    // New timer levels, and pin 3 pulled low by the board
    @(posedge clk_i);
    tmr <= 3'h6;
    ext <= 8'h00;
    settle;
    chk(pad_o[2:0], 3'h6);
    chk(cap, 1'b0);
    wb(1'b1, ADR_DIRECTION, 32'h0F);
    wb(1'b1, ADR_MODE, 32'h00);
    wb(1'b1, ADR_PULLUP, 32'hFF);
    settle;
    chk(oe_n, 8'hF0);
    chk(pu_on, 8'hF0);
    chk(cap, 1'b0);
    wb(1'b0, ADR_PINS, 32'h0);
    chk(rd, 32'hFA);
    wb(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    // Unused code 7 must leave the port active
    wb(1'b1, ADR_OPMODE, 32'h7);
    wb(1'b1, ADR_DATA, 32'h33);
    settle;
    chk(pad_o[3:0], 4'h3);
    for (int c = 2; c < 5; c++) begin
      wb(1'b1, ADR_OPMODE, c);
      wb(1'b1, ADR_DATA, 32'h0C);
      settle;
      chk(pad_o[3:0], 4'h3);
    end
    wb(1'b1, ADR_OPMODE, OPCODE_SUBACTIVE);
    settle;
    chk(pad_o[3:0], 4'hC);
    // A write without byte lane zero is acked but ignored
    lanes = 4'h0;
    wb(1'b1, ADR_DATA, 32'h03);
    lanes = 4'hF;
    settle;
    chk(pad_o[3:0], 4'hC);
    wb(1'b1, ADR_OPMODE, OPCODE_STANDBY);
    settle;
    chk(oe_n, 8'h0F);
    chk(pad_o[7:4], 4'hF);
    complete_run;
  end
endmodule : testbench
